// [core/serial_unit_cfg.svh]
/*
 * Named constants for the universal serial shift unit: field widths, reset
 * values, clock source codes and wire modes.
 * Assumes it is included by bare name wherever a constant is needed.
 */
// Notes on behaviour
// - Eight-bit shift register, processor reads and writes
// - No receive buffer; new bits overwrite
// - Register MSB drives pin chosen by mode
// - Output latch changes on opposite edge
// - Serial input always from data-input pin
// - Four-bit counter, readable, writable, overflow interrupt
// - Register and counter clocked together
// - External clock counts both edges
// - Clock from pin, timer match, software
// - Two-wire start condition detected, interrupt raised
// - Two-wire clock held low after start/overflow
// - Interrupts wake from idle; two-wire from all
// - Clock pin driven only to hold it low in two-wire; far side supplies pin clock
// - Edge select chooses sample and shift edges
// - Byte under external clock: sixteen edges
`ifndef SERIAL_UNIT_CFG_SVH
`define SERIAL_UNIT_CFG_SVH
`define DATA_W 8
`define CNT_W 4
`define DATA_RST 8'h00
`define CNT_RST 4'h0
`define CNT_MAX 4'hf
`define SRC_NONE 2'h0
`define SRC_PIN 2'h1
`define SRC_TIMER 2'h2
`define SRC_SOFT 2'h3
`define MODE_OFF 2'h0
`define MODE_THREE 2'h1
`define MODE_TWO 2'h2
`endif

// [core/serial_unit_pkg.sv]
/*
 * Types shared by the serial unit files.
 * Assumes the constants header is compiled alongside.
 */
package serial_unit_pkg;
  // Detector state for the two-wire start condition
  typedef enum logic [1:0] {st_idle, st_start, st_hold} start_state_e;
endpackage : serial_unit_pkg

// [core/pin_sync.sv]
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta; // First stage, read only by the second
  logic next_meta;
  logic next_sync_out;
  // Next values are simply the previous stage
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end
  // Register both stages; during reset the stages keep following the pin,
  // so a pin that idles high gives no false edge once reset is released
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta <= async_in;
      sync_out <= meta;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule : pin_sync

// [core/universal_serial_shift_unit.sv]
/*
 * Universal serial shift unit: shift register, edge counter, output latch,
 * clock source select and two-wire start detector with clock stretching.
 * Assumes the processor side is on sys_clk and pins are asynchronous.
 */
`timescale 1ns/1ps
`include "serial_unit_cfg.svh"
module universal_serial_shift_unit #(
  parameter int DATA_W = `DATA_W,
  parameter int CNT_W = `CNT_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] wire_mode,
  input wire logic [1:0] clock_source,
  input wire logic clock_edge_select,
  input wire logic soft_strobe,
  input wire logic timer_zero_compare_source,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic cnt_wr,
  input wire logic [CNT_W-1:0] cnt_wdata,
  input wire logic ovf_clear,
  input wire logic start_clear,
  input wire logic start_irq_en,
  input wire logic ovf_irq_en,
  input wire logic serial_data_in_pin,
  input wire logic shift_clock_pin,
  output logic [DATA_W-1:0] data_rdata,
  output logic [CNT_W-1:0] cnt_rdata,
  output logic counter_overflow_flag,
  output logic start_flag,
  output logic data_out_three,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  output logic irq,
  output logic wake_idle,
  output logic wake_deep
);
  // Only the byte-wide register and the four-bit counter are built
  if (DATA_W != `DATA_W || CNT_W != `CNT_W) begin : g_bad_width
    $error("Unsupported width");
  end

  // Synchronised pin levels
  logic di_s, ck_s, ck_d, di_d;
  pin_sync u_sync_di (.sys_clk(sys_clk), .srst(srst), .async_in(serial_data_in_pin), .sync_out(di_s));
  pin_sync u_sync_ck (.sys_clk(sys_clk), .srst(srst), .async_in(shift_clock_pin), .sync_out(ck_s));

  logic ck_rise, ck_fall, two_wire, sample_ev, shift_ev;
  logic [DATA_W-1:0] shreg, next_shreg;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic sampled, next_sampled; // Bit caught on the sample edge
  logic out_latch, next_out_latch;
  logic ovf, next_ovf;
  logic stf, next_stf;
  serial_unit_pkg::start_state_e st, next_st;
  logic next_di_d, next_ck_d;
  logic start_cond; // Data falls while clock high, two-wire only

  assign start_cond = two_wire && ck_s && di_d && !di_s;

  assign two_wire = (wire_mode == `MODE_TWO);
  assign ck_rise = ck_s & ~ck_d;
  assign ck_fall = ~ck_s & ck_d;

  // Clock source select; soft and timer give one combined tick
  always_comb begin
    sample_ev = 1'b0;
    shift_ev = 1'b0;
    case (clock_source)
      `SRC_PIN: begin
        // Edge select swaps sample and shift edges
        sample_ev = clock_edge_select ? ck_fall : ck_rise;
        shift_ev = clock_edge_select ? ck_rise : ck_fall;
      end
      `SRC_TIMER: begin
        sample_ev = timer_zero_compare_source;
        shift_ev = timer_zero_compare_source;
      end
      `SRC_SOFT: begin
        sample_ev = soft_strobe;
        shift_ev = soft_strobe;
      end
      default: begin
        sample_ev = 1'b0;
      end
    endcase
  end

  // Data, counter and flags next values
  always_comb begin
    next_shreg = shreg;
    next_cnt = cnt;
    next_sampled = sampled;
    next_out_latch = out_latch;
    next_ovf = ovf;
    next_di_d = di_s;
    next_ck_d = ck_s;
    if (clock_source == `SRC_PIN) begin
      // Sample on one edge, shift on the other; counter sees both
      if (sample_ev) next_sampled = di_s;
      if (shift_ev) next_shreg = {shreg[DATA_W-2:0], sampled};
      if (sample_ev || shift_ev) next_cnt = cnt + 1'b1;
    end else if (sample_ev) begin
      // Internal tick shifts one bit and counts once
      next_shreg = {shreg[DATA_W-2:0], di_s};
      next_cnt = cnt + 1'b1;
    end
    if ((sample_ev || shift_ev) && cnt == `CNT_MAX) next_ovf = 1'b1;
    else if (ovf_clear) next_ovf = 1'b0; // Set wins over clear
    // Output latch is transparent only away from the sample edge
    if (!sample_ev) next_out_latch = next_shreg[DATA_W-1];
    if (data_wr) begin
      next_shreg = data_wdata;
      next_out_latch = data_wdata[DATA_W-1];
    end
    if (cnt_wr) next_cnt = cnt_wdata;
  end

  // Start detector: data falls while clock high
  always_comb begin
    // Clear is applied first so that a start in the same cycle wins
    next_stf = start_clear ? 1'b0 : stf;
    next_st = st;
    case (st)
      serial_unit_pkg::st_idle: begin
        if (start_cond) begin
          next_stf = 1'b1;
          next_st = serial_unit_pkg::st_start;
        end
      end
      serial_unit_pkg::st_start: begin
        // Hold the clock low once the master pulls it low
        if (!ck_s) next_st = serial_unit_pkg::st_hold;
      end
      serial_unit_pkg::st_hold: begin
        if (!stf && !ovf) next_st = serial_unit_pkg::st_idle;
      end
      default: next_st = serial_unit_pkg::st_idle;
    endcase
    if (!two_wire) next_st = serial_unit_pkg::st_idle;
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shreg <= `DATA_RST;
      cnt <= `CNT_RST;
      sampled <= 1'b0;
      out_latch <= 1'b0;
      ovf <= 1'b0;
      stf <= 1'b0;
      st <= serial_unit_pkg::st_idle;
      // Track the pins through reset so no edge is seen at release
      di_d <= di_s;
      ck_d <= ck_s;
    end else begin
      shreg <= next_shreg;
      cnt <= next_cnt;
      sampled <= next_sampled;
      out_latch <= next_out_latch;
      ovf <= next_ovf;
      stf <= next_stf;
      st <= next_st;
      di_d <= next_di_d;
      ck_d <= next_ck_d;
    end
  end

  // Registered outputs; pins are open-drain in two-wire mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_rdata <= `DATA_RST;
      cnt_rdata <= `CNT_RST;
      counter_overflow_flag <= 1'b0;
      start_flag <= 1'b0;
      data_out_three <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      irq <= 1'b0;
      wake_idle <= 1'b0;
      wake_deep <= 1'b0;
    end else begin
      data_rdata <= next_shreg;
      cnt_rdata <= next_cnt;
      counter_overflow_flag <= next_ovf;
      start_flag <= next_stf;
      data_out_three <= (wire_mode == `MODE_THREE) ? next_out_latch : 1'b0;
      sda_out <= 1'b0;
      sda_oe <= two_wire && !next_out_latch;
      scl_out <= 1'b0;
      // Stretch after start seen or while overflow pending and the clock is low
      scl_oe <= two_wire && (next_st == serial_unit_pkg::st_hold || (next_ovf && !ck_s));
      irq <= (next_ovf && ovf_irq_en) || (next_stf && start_irq_en);
      wake_idle <= (next_ovf && ovf_irq_en) || (next_stf && start_irq_en);
      wake_deep <= two_wire && ((next_ovf && ovf_irq_en) || (next_stf && start_irq_en));
    end
  end

  // Sixteen pin edges from zero give an overflow
  property p_ovf_set;
    @(posedge sys_clk) disable iff (srst)
      (clock_source == `SRC_PIN && (sample_ev || shift_ev) && cnt == `CNT_MAX && !cnt_wr)
        |=> (ovf && cnt == `CNT_RST);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow not set on wrap");

  property p_sticky;
    @(posedge sys_clk) disable iff (srst)
      ovf && !ovf_clear |=> ovf;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Overflow flag dropped");

  property p_count_edge;
    @(posedge sys_clk) disable iff (srst)
      (clock_source == `SRC_PIN && ck_fall && !cnt_wr) |=> cnt == $past(cnt) + 1'b1;
  endproperty
  a_count_edge: assert property (p_count_edge) else $error("Falling edge not counted");

  property p_cnt_wr;
    @(posedge sys_clk) disable iff (srst)
      cnt_wr |=> cnt == $past(cnt_wdata);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("Counter write lost");

  property p_data_wr;
    @(posedge sys_clk) disable iff (srst)
      data_wr |=> shreg == $past(data_wdata) && data_rdata == $past(data_wdata);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("Data write lost");

  property p_soft_shift;
    @(posedge sys_clk) disable iff (srst)
      (clock_source == `SRC_SOFT && soft_strobe && !data_wr) |=> shreg[0] == $past(di_s);
  endproperty
  a_soft_shift: assert property (p_soft_shift) else $error("Input not shifted in");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (srst)
      (sample_ev && !data_wr) |=> out_latch == $past(out_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Output moved on sample edge");

  sequence s_start;
    two_wire && ck_s && di_d && !di_s && st == serial_unit_pkg::st_idle;
  endsequence
  property p_start;
    @(posedge sys_clk) disable iff (srst)
      s_start |=> stf && start_flag;
  endproperty
  a_start: assert property (p_start) else $error("Start not flagged");

  property p_three_off;
    @(posedge sys_clk) disable iff (srst)
      wire_mode == `MODE_THREE |=> !sda_oe && !scl_oe;
  endproperty
  a_three_off: assert property (p_three_off) else $error("Two-wire pins driven in three-wire");
endmodule : universal_serial_shift_unit

// [sim/serial_peer_model.sv]
/*
 * Far-side serial master: clocks eight pulses, MSB first.
 * Assumes the clock idles at idle_high: low suits edge select 0, high suits
 * edge select 1; data is set up before the leading edge and read on it.
 */
`timescale 1ns/1ps
module serial_peer_model (
  input wire logic go,
  input wire logic [7:0] tx_byte,
  input wire logic dout,
  input wire logic idle_high,
  output logic sck,
  output logic sdi,
  output logic [7:0] rx_byte,
  output logic busy
);
  // Clock starts low; idle_high then sets its level outside frames
  initial begin
    sck = 0;
    sdi = 0;
    rx_byte = 0;
    busy = 0;
  end
  // Idle level follows the chosen phase while no frame runs
  always @(idle_high) begin
    if (!busy) sck = idle_high;
  end
  // One byte frame; the master always makes the clock
  always @(posedge go) begin : frame
    int i;
    busy = 1;
    for (i = 7; i >= 0; i--) begin
      sdi = tx_byte[i];
      #200 sck = ~idle_high;
      rx_byte = {rx_byte[6:0], dout};
      #200 sck = idle_high;
    end
    // Released line shows the inverse, so a stale value never matches
    sdi = ~sdi;
    busy = 0;
  end
endmodule : serial_peer_model

// [sim/test_universal_serial_shift_unit.sv]
/*
 * Self-checking bench for the serial shift unit with an integer model.
 * Assumes the peer model and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "serial_unit_cfg.svh"
module test_universal_serial_shift_unit;
  logic sys_clk = 0, srst = 1, edge_sel = 0, strobe = 0, tmr = 0, dwr = 0, cwr = 0;
  logic oclr = 0, sclr = 0, sien = 1, oien = 1, tb_sda = 0, tb_scl = 0, go = 0, use_peer = 0, pidle = 0;
  logic [1:0] mode = 0, src = 0;
  logic [7:0] wdata = 0, rdata, ptx = 0, prx, exp_data;
  logic [3:0] cwdata = 0, crdata;
  logic ovf, stf, d3, sdo, sdoe, sclo, scloe, irq, wki, wkd, psck, psdi, pbusy;
  int fails = 0, num_checks = 0, seed = 29164, exp_cnt, i, s;
  // Pins come from the peer during pin-clocked frames, else from the bench
  wire din = use_peer ? psdi : tb_sda;
  wire sck = use_peer ? psck : tb_scl;
  always #25 sys_clk = ~sys_clk;
  universal_serial_shift_unit i_universal_serial_shift_unit (.sys_clk(sys_clk), .srst(srst),
    .wire_mode(mode), .clock_source(src), .clock_edge_select(edge_sel), .soft_strobe(strobe),
    .timer_zero_compare_source(tmr), .data_wr(dwr), .data_wdata(wdata), .cnt_wr(cwr),
    .cnt_wdata(cwdata), .ovf_clear(oclr), .start_clear(sclr), .start_irq_en(sien),
    .ovf_irq_en(oien), .serial_data_in_pin(din), .shift_clock_pin(sck), .data_rdata(rdata),
    .cnt_rdata(crdata), .counter_overflow_flag(ovf), .start_flag(stf), .data_out_three(d3),
    .sda_out(sdo), .sda_oe(sdoe), .scl_out(sclo), .scl_oe(scloe), .irq(irq), .wake_idle(wki),
    .wake_deep(wkd));
  serial_peer_model i_serial_peer_model (.go(go), .tx_byte(ptx), .dout(d3), .idle_high(pidle), .sck(psck),
    .sdi(psdi), .rx_byte(prx), .busy(pbusy));
  // Compare and count
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task report_and_stop;
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Load register and counter in one pulse each
  task load(input logic [7:0] d, input logic [3:0] c);
    @(negedge sys_clk) {dwr, cwr, wdata, cwdata} = {2'b11, d, c};
    @(negedge sys_clk) {dwr, cwr} = 2'b00;
    exp_data = d;
    exp_cnt = c;
  endtask : load
  // One internal tick; din is set early so the synchroniser has settled
  task tick(input logic b, input logic timer);
    tb_sda = b;
    repeat (4) @(negedge sys_clk);
    if (timer) tmr = 1;
    else strobe = 1;
    @(negedge sys_clk) {tmr, strobe} = 2'b00;
    if (src != `SRC_NONE) begin
      exp_data = {exp_data[6:0], b};
      exp_cnt = (exp_cnt + 1) % 16;
    end
    chk("data", rdata, exp_data);
    chk("count", crdata, exp_cnt);
  endtask : tick
  // Watchdog cuts a hang short
  initial begin
    #2000000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    srst = 0;
    @(negedge sys_clk);
    chk("rst", {rdata, crdata, ovf, stf, irq}, 0);
    mode = `MODE_THREE;
    // Timer, software, then no-source ticks; counter preset so the eighth tick wraps when clocked
    for (s = 0; s < 3; s++) begin
      src = (s == 0) ? `SRC_TIMER : ((s == 1) ? `SRC_SOFT : `SRC_NONE);
      load($random(seed), 4'h8);
      for (i = 0; i < 8; i++) tick($random(seed), s == 0);
      chk("ovf", ovf, s < 2);
      chk("irq", {irq, wki}, {2{s < 2}});
      // The output latch follows the register one cycle after the tick
      @(negedge sys_clk);
      chk("dout", d3, exp_data[7]);
      @(negedge sys_clk) oclr = 1;
      @(negedge sys_clk) oclr = 0;
      @(negedge sys_clk) chk("ovfclr", ovf, 0);
    end
    // Pin-clocked bytes in both edge selects: sixteen edges make one overflow
    src = `SRC_PIN;
    use_peer = 1;
    for (s = 0; s < 2; s++) begin
      // Idle level of the clock moves before the load, so a stray edge is overwritten
      {go, edge_sel, pidle, oclr} = {1'b0, s[0], s[0], 1'b1};
      @(negedge sys_clk) oclr = 0;
      repeat (6) @(negedge sys_clk);
      ptx = $random(seed);
      load($random(seed), 4'h0);
      @(negedge sys_clk) go = 1;
      repeat (10) @(negedge sys_clk);
      wait (!pbusy);
      repeat (10) @(negedge sys_clk);
      chk("rx", rdata, ptx);
      chk("tx", prx, exp_data);
      chk("edges", {ovf, crdata}, 5'h10);
    end
    // Two-wire start condition and clock hold; overflow cleared so only the start wakes
    {go, use_peer, mode, tb_scl, tb_sda, oclr} = {2'b00, `MODE_TWO, 3'b111};
    @(negedge sys_clk) oclr = 0;
    repeat (5) @(negedge sys_clk);
    tb_sda = 0;
    repeat (6) @(negedge sys_clk);
    chk("start", {stf, wkd}, 2'b11);
    tb_scl = 0;
    repeat (6) @(negedge sys_clk);
    chk("hold", {scloe, sclo, sdoe, sdo}, {2'b10, ~ptx[7], 1'b0});
    {sclr, oclr} = 2'b11;
    @(negedge sys_clk) {sclr, oclr} = 2'b00;
    repeat (4) @(negedge sys_clk);
    chk("release", {stf, scloe}, 0);
    report_and_stop;
  end
endmodule : test_universal_serial_shift_unit
